// ===== logic/isas_pkg.sv
// constants, types and decode functions of the two-wire register target
// assumes one bus target per strap setting and 8-bit register addressing
package isas_pkg;

  // identifier range selected by the straps
  localparam logic [6:0] ID_BASE            = 7'h6C;

  // register offsets
  localparam logic [7:0] REG_STATUS         = 8'h01;
  localparam logic [7:0] REG_AUDIO_PORT_CFG = 8'h02;
  localparam logic [7:0] REG_MANUAL_SLOT    = 8'h03;

  // field positions
  localparam int unsigned SLOT_SOURCE_SELECT_BIT = 6;
  localparam int unsigned MANUAL_SLOT_LSB        = 0;
  localparam int unsigned STATUS_SLOT_LSB        = 0;
  localparam int unsigned STATUS_STRAP_LSB       = 4;
  localparam int unsigned SLOT_W                 = 3;

  // reset values and the value read from unmapped offsets
  localparam logic [7:0] AUDIO_PORT_CFG_RST = 8'h00;
  localparam logic [7:0] MANUAL_SLOT_RST    = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // strap level codes: short to ground, resistor to ground, resistor up, short up
  localparam logic [1:0] LVL_GND_SHORT      = 2'h0;

  // timing counts in core clock cycles
  localparam logic [2:0] LINK_RST_CYCLES    = 3'h4;
  localparam logic [1:0] STRAP_SETTLE       = 2'h3;

  typedef logic [SLOT_W-1:0] isas_slot_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_SKIP
  } isas_state_e;

  // offset from the base identifier; the high strap only knows two levels
  function automatic isas_slot_t strap_offset(input logic [1:0] hi, input logic [1:0] lo);
    strap_offset = {(hi != LVL_GND_SHORT), lo};
  endfunction

  // slot in use: manual field when selected, strap offset otherwise
  function automatic isas_slot_t pick_slot(input logic src, input isas_slot_t manual,
                                           input isas_slot_t strap);
    pick_slot = src ? manual : strap;
  endfunction

endpackage

// ===== logic/isas_sync2.sv
// two-flop level synchroniser, one bit lane per data bit
// assumes each lane is a level that holds for several destination clocks
`timescale 1ns/1ps
module isas_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } isas_sync_s;

  isas_sync_s s_q;
  isas_sync_s s_d;

  always_comb
  begin
    s_d.meta = d_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.sync;

endmodule // isas_sync2

// ===== logic/isas_target.sv
// two-wire bus register target with strap-selected identifier and slot choice
// assumes the bus clock toggles only inside frames and idles high between them
`timescale 1ns/1ps
module isas_target
  import isas_pkg::*;
(
  // core clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  // two-wire bus; the bus clock is the link clock
  input  wire logic             scl_clk_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_out,
  // address straps, level codes 0..3
  input  wire logic [1:0]       strap_pin_high_in,
  input  wire logic [1:0]       strap_pin_low_in,
  // audio receiver side
  output isas_pkg::isas_slot_t  time_slot_out,
  output logic      [6:0]       bus_target_identifier_out
);

  typedef struct packed {
    logic [1:0] settle;
    isas_slot_t strap_off;
    logic       scl_prev;
    logic       sda_prev;
    logic [2:0] hold_cnt;
    logic       link_hold;
    logic [3:0] cfg_prev;
    isas_slot_t slot;
    logic [6:0] ident;
    logic       sda_val;
  } isas_core_s;

  typedef struct packed {
    isas_state_e st;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        first;
    logic        rd;
    logic        oe;
  } isas_eng_s;

  typedef struct packed {
    logic [7:0] audio_cfg;
    logic [7:0] manual_slot;
  } isas_regs_s;

  isas_core_s c_q;
  isas_core_s c_d;
  isas_eng_s  e_q;
  isas_eng_s  e_d;
  isas_regs_s r_q;
  isas_regs_s r_d;

  logic [3:0] strap_s;
  logic [1:0] bus_s;
  logic [3:0] cfg_s;
  isas_slot_t link_strap_off;
  logic       link_rst_n;
  logic       sda_rise_q;
  logic       start_seen;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [6:0] link_id;
  logic       go_tx;
  logic       wr_en;
  isas_slot_t link_slot;

  // core clock domain

  isas_sync2 #(.W(4)) u_strap_sync (
    .clk_in  (core_clk_in),
    .nrst_in (nrst_in),
    .d_in    ({strap_pin_high_in, strap_pin_low_in}),
    .q_out   (strap_s)
  );

  isas_sync2 #(.W(2)) u_bus_sync (
    .clk_in  (core_clk_in),
    .nrst_in (nrst_in),
    .d_in    ({scl_clk_in, sda_in}),
    .q_out   (bus_s)
  );

  isas_sync2 #(.W(4)) u_cfg_sync (
    .clk_in  (core_clk_in),
    .nrst_in (nrst_in),
    .d_in    ({r_q.audio_cfg[SLOT_SOURCE_SELECT_BIT],
               r_q.manual_slot[MANUAL_SLOT_LSB +: SLOT_W]}),
    .q_out   (cfg_s)
  );

  always_comb
  begin
    c_d          = c_q;
    c_d.scl_prev = bus_s[1];
    c_d.sda_prev = bus_s[0];
    c_d.sda_val  = 1'b0;
    // straps are followed until they settle after reset, then frozen
    if (c_q.settle != STRAP_SETTLE)
    begin
      c_d.settle    = c_q.settle + 2'h1;
      c_d.strap_off = strap_offset(strap_s[3:2], strap_s[1:0]);
    end
    c_d.ident = ID_BASE + {4'h0, c_q.strap_off};
    // a stop returns the link logic to idle through a short reset pulse
    if (bus_s[1] && c_q.scl_prev && bus_s[0] && !c_q.sda_prev)
    begin
      c_d.hold_cnt = LINK_RST_CYCLES;
    end
    else if (c_q.hold_cnt != 3'h0)
    begin
      c_d.hold_cnt = c_q.hold_cnt - 3'h1;
    end
    c_d.link_hold = (c_d.hold_cnt != 3'h0);
    // the slot is taken only from two equal samples, so bit skew never shows
    c_d.cfg_prev = cfg_s;
    if (cfg_s == c_q.cfg_prev)
    begin
      c_d.slot = pick_slot(c_q.cfg_prev[3], c_q.cfg_prev[2:0], c_q.strap_off);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      c_q <= '0;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  assign link_rst_n                = nrst_in & ~c_q.link_hold;
  assign sda_out                   = c_q.sda_val;
  assign time_slot_out             = c_q.slot;
  assign bus_target_identifier_out = c_q.ident;

  // bus clock domain

  isas_sync2 #(.W(SLOT_W)) u_off_sync (
    .clk_in  (scl_clk_in),
    .nrst_in (nrst_in),
    .d_in    (c_q.strap_off),
    .q_out   (link_strap_off)
  );

  // data as seen during the clock-high phase; reset high so the first fall finds a start
  always_ff @(posedge scl_clk_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      sda_rise_q <= 1'b1;
    end
    else
    begin
      sda_rise_q <= sda_in;
    end
  end

  assign link_id    = ID_BASE + {4'h0, link_strap_off};
  assign link_slot  = pick_slot(r_q.audio_cfg[SLOT_SOURCE_SELECT_BIT],
                                r_q.manual_slot[MANUAL_SLOT_LSB +: SLOT_W], link_strap_off);
  assign start_seen = sda_rise_q & ~sda_in;
  assign rx_byte    = {e_q.sh[6:0], sda_rise_q};
  assign go_tx      = ((e_q.st == ST_ACK) && e_q.rd) || ((e_q.st == ST_MACK) && !sda_rise_q);

  always_comb
  begin
    unique case (e_q.ptr)
      REG_STATUS:
      begin
        tx_byte = READ_UNMAPPED;
        tx_byte[STATUS_SLOT_LSB +: SLOT_W]  = link_slot;
        tx_byte[STATUS_STRAP_LSB +: SLOT_W] = link_strap_off;
      end
      REG_AUDIO_PORT_CFG: tx_byte = r_q.audio_cfg;
      REG_MANUAL_SLOT:    tx_byte = r_q.manual_slot;
      default:            tx_byte = READ_UNMAPPED;
    endcase
  end

  // engine moves on each falling bus clock edge; it only ever releases or pulls data low
  always_comb
  begin
    e_d   = e_q;
    wr_en = 1'b0;
    if (start_seen)
    begin
      e_d.st  = ST_ADDR;
      e_d.cnt = 3'h0;
      e_d.oe  = 1'b0;
    end
    else
    begin
      unique case (e_q.st)
        ST_IDLE, ST_SKIP:
        begin
          e_d.oe = 1'b0;
        end
        ST_ADDR, ST_RX:
        begin
          e_d.sh  = rx_byte;
          e_d.cnt = e_q.cnt + 3'h1;
          if (e_q.cnt == 3'h7)
          begin
            if (e_q.st == ST_ADDR)
            begin
              if (rx_byte[7:1] == link_id)
              begin
                e_d.st    = ST_ACK;
                e_d.oe    = 1'b1;
                e_d.rd    = rx_byte[0];
                e_d.first = ~rx_byte[0];
              end
              else
              begin
                e_d.st = ST_SKIP;
              end
            end
            else
            begin
              e_d.st = ST_ACK;
              e_d.oe = 1'b1;
              if (e_q.first)
              begin
                e_d.ptr   = rx_byte;
                e_d.first = 1'b0;
              end
              else
              begin
                wr_en     = 1'b1;
                e_d.ptr   = e_q.ptr + 8'h01;
              end
            end
          end
        end
        ST_ACK, ST_MACK:
        begin
          e_d.cnt = 3'h0;
          e_d.oe  = 1'b0;
          if (go_tx)
          begin
            e_d.st  = ST_TX;
            e_d.sh  = tx_byte;
            e_d.oe  = ~tx_byte[7];
            e_d.ptr = e_q.ptr + 8'h01;
          end
          else if (e_q.st == ST_ACK)
          begin
            e_d.st = ST_RX;
          end
          else
          begin
            e_d.st = ST_SKIP;
          end
        end
        ST_TX:
        begin
          if (e_q.cnt == 3'h7)
          begin
            e_d.st = ST_MACK;
            e_d.oe = 1'b0;
          end
          else
          begin
            e_d.cnt = e_q.cnt + 3'h1;
            e_d.sh  = {e_q.sh[6:0], 1'b0};
            e_d.oe  = ~e_q.sh[6];
          end
        end
        default:
        begin
          e_d.st = ST_IDLE;
          e_d.oe = 1'b0;
        end
      endcase
    end
  end

  // no stretching: state advances only on bus edges, at any bus rate
  always_ff @(negedge scl_clk_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      e_q <= '{st: ST_IDLE, cnt: 3'h0, sh: 8'h00, ptr: 8'h00, first: 1'b0, rd: 1'b0, oe: 1'b0};
    end
    else
    begin
      e_q <= e_d;
    end
  end

  assign sda_oe_out = e_q.oe;

  // register file survives the per-frame link reset
  always_comb
  begin
    r_d = r_q;
    if (wr_en)
    begin
      unique case (e_q.ptr)
        REG_AUDIO_PORT_CFG: r_d.audio_cfg   = rx_byte;
        REG_MANUAL_SLOT:    r_d.manual_slot = rx_byte;
        default:            r_d = r_q;
      endcase
    end
  end

  always_ff @(negedge scl_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      r_q <= '{audio_cfg: AUDIO_PORT_CFG_RST, manual_slot: MANUAL_SLOT_RST};
    end
    else
    begin
      r_q <= r_d;
    end
  end

endmodule // isas_target

// ===== verification/i2c_slave_with_address_straps_test.sv
// self-checking bench of the two-wire register target
// assumes frames are started at falling core clock edges
`timescale 1ns/1ps
module i2c_slave_with_address_straps_test;
  import isas_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [1:0] hi = 2'h0;
  logic [1:0] lo = 2'h0;
  logic       scl;
  logic       m_low;
  logic       sda;
  logic       sdo;
  logic       oe;
  isas_slot_t slot;
  logic [6:0] id;
  logic [6:0] cur;
  int         n_errors = 0;
  int         compares = 0;

  always #5 clk = !clk;
  // wired-and with pull-up
  assign sda = !(m_low || (oe && !sdo));

  isas_target uut (.core_clk_in(clk), .nrst_in(nrst), .scl_clk_in(scl), .sda_in(sda),
    .sda_out(sdo), .sda_oe_out(oe), .strap_pin_high_in(hi), .strap_pin_low_in(lo),
    .time_slot_out(slot), .bus_target_identifier_out(id));
  isas_ctl_model ctl (.nrst_in(nrst), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_a(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t ack %b expected %b", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic boot(input logic [1:0] h, input logic [1:0] l);
    @(posedge clk);
    nrst <= 1'b0;
    hi <= h;
    lo <= l;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  task automatic head(input logic [6:0] a, input logic rw, input logic exp);
    logic [7:0] q;
    logic       k;
    @(negedge clk);
    ctl.start();
    ctl.xfer({a, rw}, 1'b0, q, k);
    chk_a(k, exp);
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1,
                    input logic two);
    logic [7:0] q;
    logic       k;
    head(cur, 1'b0, 1'b1);
    ctl.xfer(r, 1'b0, q, k);
    chk_a(k, 1'b1);
    ctl.xfer(d0, 1'b0, q, k);
    chk_a(k, 1'b1);
    if (two)
    begin
      ctl.xfer(d1, 1'b0, q, k);
      chk_a(k, 1'b1);
    end
    ctl.stop();
  endtask

  task automatic rd3(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1,
                     input logic [7:0] e2);
    logic [7:0] q;
    logic       k;
    head(cur, 1'b0, 1'b1);
    ctl.xfer(r, 1'b0, q, k);
    chk_a(k, 1'b1);
    head(cur, 1'b1, 1'b1);
    ctl.xfer(8'hFF, 1'b1, q, k);
    chk_v(q, e0);
    ctl.xfer(8'hFF, 1'b1, q, k);
    chk_v(q, e1);
    ctl.xfer(8'hFF, 1'b0, q, k);
    chk_v(q, e2);
    ctl.stop();
  endtask

  // all eight identifier offsets: identifier, default slot, own and foreign address
  task automatic t_straps();
    logic [1:0] h;
    for (int i = 0; i < 8; i++)
    begin
      h = (i < 4) ? 2'h0 : 2'(i % 3 + 1);
      boot(h, 2'(i));
      cur = ID_BASE + 7'(i);
      chk_v({1'b0, id}, {1'b0, cur});
      chk_v({5'h0, slot}, 8'(i));
      head(cur, 1'b0, 1'b1);
      ctl.stop();
      head(cur ^ 7'h08, 1'b0, 1'b0);
      ctl.stop();
    end
  endtask

  // reset values, manual slot, pointer wrap and unmapped reads
  task automatic t_regs();
    boot(2'h3, 2'h1);
    cur = ID_BASE + 7'h05;
    rd3(REG_STATUS, 8'h55, AUDIO_PORT_CFG_RST, MANUAL_SLOT_RST);
    wr(REG_AUDIO_PORT_CFG, 8'h40, 8'h03, 1'b1);
    repeat (20) @(posedge clk);
    chk_v({5'h0, slot}, 8'h03);
    rd3(REG_STATUS, 8'h53, 8'h40, 8'h03);
    rd3(8'hFF, READ_UNMAPPED, READ_UNMAPPED, 8'h53);
    wr(REG_AUDIO_PORT_CFG, 8'h00, 8'h00, 1'b0);
    repeat (20) @(posedge clk);
    chk_v({5'h0, slot}, 8'h05);
  endtask

  initial
  begin
    t_straps();
    t_regs();
    report_and_stop();
  end

  // about twenty frames of under three microseconds each
  initial
  begin
    #200us;
    n_errors++;
    report_and_stop();
  end
endmodule // i2c_slave_with_address_straps_test

// ===== verification/isas_ctl_model.sv
// two-wire bus controller model for the target's bus pins
// assumes it is started at even ns times; all its delays are even
`timescale 1ns/1ps
module isas_ctl_model #(
  parameter int unsigned START_NS = 100
) (
  // power-up seen through reset
  input  wire logic nrst_in,
  // bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  time t_up;
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    t_up = 0;
  end
  always @(posedge nrst_in) t_up = $time;

  task automatic start();
    while ($time < t_up + START_NS) #2;
    sda_low_out = 1'b0;
    #12 scl_out = 1'b1;
    #24 sda_low_out = 1'b1;
    #24 scl_out = 1'b0;
  endtask

  task automatic bit_io(input logic b, output logic r);
    #12 sda_low_out = !b;
    #12 scl_out = 1'b1;
    #12 r = sda_in;
    #12 scl_out = 1'b0;
  endtask

  // nine clocks: eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(!m_ack, r);
    ack = !r;
  endtask

  task automatic stop();
    #12 sda_low_out = 1'b1;
    #12 scl_out = 1'b1;
    #24 sda_low_out = 1'b0;
    #100;
  endtask
endmodule // isas_ctl_model

// ===== verification/isas_target_sva.sv
// pin checker of the two-wire register target, bound to isas_target
// assumes straps only change while nrst_in is low
`timescale 1ns/1ps
module isas_target_sva
  import isas_pkg::*;
(
  // clock and reset
  input wire logic                core_clk_in,
  input wire logic                nrst_in,
  // bus
  input wire logic                scl_clk_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe_out,
  // straps and outputs
  input wire logic [1:0]          strap_pin_high_in,
  input wire logic [1:0]          strap_pin_low_in,
  input wire isas_pkg::isas_slot_t time_slot_out,
  input wire logic [6:0]          bus_target_identifier_out
);
  logic [3:0] up_q;
  logic       settled;
  assign settled = up_q >= 4'hA;
  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
      up_q <= 4'h0;
    else if (up_q != 4'hF)
      up_q <= up_q + 4'h1;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sda_low_a: assert property (sda_out == 1'b0)
    else $error("data driven high");
  id_decode_a: assert property (settled |-> bus_target_identifier_out ==
    ID_BASE + {4'h0, strap_pin_high_in != LVL_GND_SHORT, strap_pin_low_in})
    else $error("identifier decode wrong");
  id_steady_a: assert property (settled |-> $stable(bus_target_identifier_out))
    else $error("identifier moved");
  oe_rise_a: assert property ($rose(sda_oe_out) |-> !scl_clk_in)
    else $error("drive started with clock high");
  oe_fall_a: assert property ($fell(sda_oe_out) |-> !scl_clk_in)
    else $error("drive ended with clock high");
  oe_high_a: assert property (scl_clk_in && $past(scl_clk_in) |-> $stable(sda_oe_out))
    else $error("data moved while clock high");
  ack_hold_a: assert property ($rose(sda_oe_out) |-> sda_oe_out[*4])
    else $error("low drive too short");
  bus_idle_a: assert property (scl_clk_in[*8] |-> !sda_oe_out)
    else $error("data held on idle bus");

  cover property ($rose(sda_oe_out));
  cover property (settled && bus_target_identifier_out == 7'h73);
  cover property (settled && time_slot_out == 3'h3);
endmodule // isas_target_sva

bind isas_target isas_target_sva u_sva (.core_clk_in, .nrst_in, .scl_clk_in, .sda_in,
  .sda_out, .sda_oe_out, .strap_pin_high_in, .strap_pin_low_in, .time_slot_out,
  .bus_target_identifier_out);
